/* File: inc/simd_alu_pkg.sv */
// Shared types and constants of the packed-SIMD saturating datapath
package simd_alu_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int XLEN = 64;
  localparam int SHAMT_W = 6;
  localparam int FLAG_W = 8;

  // ----------------------------------------------------------------------
  // Operations, element formats and per-lane operations
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'b0000,   // Lane add
    OP_SUB = 4'b0001,   // Lane subtract
    OP_SHL = 4'b0010,   // Lane shift left
    OP_MULQ = 4'b0011,  // Fractional multiply, same-width result
    OP_MUL = 4'b0100,   // Integer multiply, same-width result
    OP_MULEQ = 4'b0101, // Fractional multiply, expanded 16 -> 32
    OP_DOT = 4'b0110,   // Fractional dot product into accumulator
    OP_PREC = 4'b0111,  // Fractional precision reduce word -> half
    OP_EXTR = 4'b1000,  // Extract word from accumulator
    OP_LOAD = 4'b1001   // Doubleword load, endian placement
  } op_t;

  typedef enum logic [2:0] {
    FMT_L = 3'b000,              // 1 x 64 signed
    FMT_PAIRED_WORD = 3'b001,    // paired_word_2x32
    FMT_W = 3'b010,              // 1 x 32 signed
    FMT_QUAD_HALF = 3'b011,      // quad_half_4x16
    FMT_PAIRED_HALF = 3'b100,    // paired_half_2x16
    FMT_OCTAL_BYTE = 3'b101,     // octal_byte_8x8
    FMT_QUAD_BYTE = 3'b110       // quad_byte_4x8
  } fmt_t;

  typedef enum logic [2:0] {
    LANE_ADD = 3'b000,
    LANE_SUB = 3'b001,
    LANE_SHL = 3'b010,
    LANE_MULQ = 3'b011,
    LANE_MUL = 3'b100
  } lane_op_t;

  // ----------------------------------------------------------------------
  // Sticky flag positions and reset values
  // ----------------------------------------------------------------------
  localparam int FLAG_ACC0 = 0;
  localparam int FLAG_ADDSUB = 4;
  localparam int FLAG_MUL = 5;
  localparam int FLAG_SHIFT = 6;
  localparam int FLAG_EXTRACT = 7;
  localparam logic [7:0] OUFLAG_RST = 8'h00;
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // Fractional limits and rounding constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] Q15_MIN = 16'h8000;
  localparam logic [15:0] Q15_MAX = 16'h7FFF;
  localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
  localparam logic [32:0] PREC_HALF_LSB = 33'h0_0000_8000;

endpackage : simd_alu_pkg

/* File: inc/lane_ctl_if.sv */
// Control bundle shared by all arithmetic lanes
`timescale 1ns/10ps
interface lane_ctl_if;
  import simd_alu_pkg::*;
  lane_op_t op;
  logic is_signed;
  logic saturate;
  logic round;
  logic [SHAMT_W-1:0] shamt;
  modport drive (output op, output is_signed, output saturate,
                 output round, output shamt);
  modport lane (input op, input is_signed, input saturate,
                input round, input shamt);
endinterface : lane_ctl_if

/* File: rtl/lane_alu.sv */
// One saturating arithmetic lane of parameterised element width
`timescale 1ns/10ps
module lane_alu #(
  parameter int W = 8
) (
  lane_ctl_if.lane ctl,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] y,
  output logic ovf
);
  import simd_alu_pkg::*;

  // Wide enough for a full W x W product plus a sign
  localparam int XW = 2 * W + 2;

  logic signed [XW-1:0] ax;
  logic signed [XW-1:0] bx;
  logic signed [XW-1:0] prod;
  logic signed [XW-1:0] wide;
  logic signed [XW-1:0] hi_lim;
  logic signed [XW-1:0] lo_lim;
  logic signed [XW-1:0] rnd;

  // ----------------------------------------------------------------------
  // Operand extension and clamp bounds
  // ----------------------------------------------------------------------
  // The operand extension and the bounds depend on signedness; the adder is shared
  always_comb begin
    ax = ctl.is_signed ? XW'(signed'(a)) : XW'(a);
    bx = ctl.is_signed ? XW'(signed'(b)) : XW'(b);
    prod = ax * bx;
    rnd = ctl.round ? (XW'(1) <<< (W - 1)) : XW'(0);
    if (ctl.is_signed) begin
      hi_lim = (XW'(1) <<< (W - 1)) - XW'(1);
      lo_lim = -(XW'(1) <<< (W - 1));
    end else begin
      hi_lim = (XW'(1) <<< W) - XW'(1);
      lo_lim = XW'(0);
    end
  end

  // ----------------------------------------------------------------------
  // Exact result before clamping
  // ----------------------------------------------------------------------
  always_comb begin
    wide = '0;
    unique case (ctl.op)
      LANE_ADD: wide = ax + bx;
      LANE_SUB: wide = ax - bx;
      LANE_SHL: wide = ax <<< ctl.shamt;
      // Half an lsb added before the cut, the clamp follows
      LANE_MULQ: wide = ((prod <<< 1) + rnd) >>> W;
      LANE_MUL: wide = prod;
    endcase
  end

  // ----------------------------------------------------------------------
  // Clamp; -1 x -1 lands one above the maximum and is caught here
  // ----------------------------------------------------------------------
  always_comb begin
    ovf = (wide > hi_lim) || (wide < lo_lim);
    y = wide[W-1:0];
    if (ovf && ctl.saturate) begin
      y = (wide > hi_lim) ? hi_lim[W-1:0] : lo_lim[W-1:0];
    end
  end

endmodule : lane_alu

/* File: rtl/simd_sat_alu.sv */
// Packed-SIMD fixed-point datapath with saturation and sticky flags
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
`timescale 1ns/10ps
module simd_sat_alu (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire simd_alu_pkg::op_t op,
  input wire simd_alu_pkg::fmt_t out_fmt,
  input wire simd_alu_pkg::fmt_t in_fmt,
  input wire logic is_signed,
  input wire logic saturate,
  input wire logic round,
  input wire logic acc_sat,
  input wire logic sel_left,
  input wire logic [5:0] shamt,
  input wire logic [1:0] acc_sel,
  input wire logic [63:0] rs_data,
  input wire logic [63:0] rt_data,
  input wire logic [63:0] acc_in,
  input wire logic big_endian,
  input wire logic [63:0] load_bytes,
  input wire logic flag_wr,
  input wire logic [7:0] flag_wdata,
  output logic result_valid,
  output logic [63:0] result_data,
  output logic acc_valid,
  output logic [63:0] acc_data,
  output logic [7:0] ouflag
);
  import simd_alu_pkg::*;

  lane_ctl_if ctl ();

  logic [63:0] y8_flat;
  logic [63:0] y16_flat;
  logic [63:0] y32_flat;
  logic [63:0] y64_flat;
  logic [7:0] ov8;
  logic [3:0] ov16;
  logic [1:0] ov32;
  logic ov64;
  logic [63:0] simd_res;
  logic simd_ovf;
  logic [63:0] ld_word;
  logic [63:0] res_next;
  logic [63:0] acc_next;
  logic acc_we;
  logic [7:0] ev;
  logic result_valid_reg;
  logic [63:0] result_reg;
  logic acc_valid_reg;
  logic [63:0] acc_reg;
  logic [7:0] ouflag_reg;
  logic [7:0] ouflag_next;

  // Sign of bit 31 copied over the upper word
  function automatic logic [63:0] sext32(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : sext32

  // Q15 x Q15 -> Q31 with the -1 x -1 case pinned to the maximum
  function automatic logic [32:0] mulq_exp(input logic [15:0] a,
                                           input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q15_MIN && b == Q15_MIN) begin
      return {1'b1, Q31_MAX};
    end
    return {1'b0, p[30:0], 1'b0};
  endfunction : mulq_exp

  // Word to half with optional rounding; only positive overflow exists
  function automatic logic [16:0] prec_half(input logic [31:0] w,
                                            input logic rnd);
    logic [32:0] r;
    r = {w[31], w} + (rnd ? PREC_HALF_LSB : 33'h0_0000_0000);
    if (r[32] != r[31]) begin
      return {1'b1, Q15_MAX};
    end
    return {1'b0, r[31:16]};
  endfunction : prec_half

  // ----------------------------------------------------------------------
  // Lane control shared by every lane instance
  // ----------------------------------------------------------------------
  always_comb begin
    ctl.is_signed = is_signed;
    ctl.saturate = saturate;
    ctl.round = round;
    ctl.shamt = shamt;
    unique case (op)
      OP_SUB: ctl.op = LANE_SUB;
      OP_SHL: ctl.op = LANE_SHL;
      OP_MULQ: ctl.op = LANE_MULQ;
      OP_MUL: ctl.op = LANE_MUL;
      default: ctl.op = LANE_ADD; // Non-lane operations ignore lanes
    endcase
  end

  // ----------------------------------------------------------------------
  // Lane arrays, one per element width
  // ----------------------------------------------------------------------
  // Every lane has its own clamp so one lane never disturbs another
  for (genvar i = 0; i < 8; i++) begin : g_lane8
    lane_alu #(.W(8)) u_lane (
      .ctl(ctl),
      .a(rs_data[8*i +: 8]),
      .b(rt_data[8*i +: 8]),
      .y(y8_flat[8*i +: 8]),
      .ovf(ov8[i])
    );
  end
  for (genvar i = 0; i < 4; i++) begin : g_lane16
    lane_alu #(.W(16)) u_lane (
      .ctl(ctl),
      .a(rs_data[16*i +: 16]),
      .b(rt_data[16*i +: 16]),
      .y(y16_flat[16*i +: 16]),
      .ovf(ov16[i])
    );
  end
  for (genvar i = 0; i < 2; i++) begin : g_lane32
    lane_alu #(.W(32)) u_lane (
      .ctl(ctl),
      .a(rs_data[32*i +: 32]),
      .b(rt_data[32*i +: 32]),
      .y(y32_flat[32*i +: 32]),
      .ovf(ov32[i])
    );
  end
  lane_alu #(.W(64)) u_lane64 (
    .ctl(ctl),
    .a(rs_data),
    .b(rt_data),
    .y(y64_flat),
    .ovf(ov64)
  );

  // ----------------------------------------------------------------------
  // Format selection; 32-bit formats sit low, sign-extended
  // ----------------------------------------------------------------------
  always_comb begin
    simd_res = '0;
    simd_ovf = 1'b0;
    unique case (out_fmt)
      FMT_OCTAL_BYTE: begin
        simd_res = y8_flat;
        simd_ovf = |ov8;
      end
      FMT_QUAD_BYTE: begin
        simd_res = sext32(y8_flat[31:0]);
        simd_ovf = |ov8[3:0];
      end
      FMT_QUAD_HALF: begin
        simd_res = y16_flat;
        simd_ovf = |ov16;
      end
      FMT_PAIRED_HALF: begin
        simd_res = sext32(y16_flat[31:0]);
        simd_ovf = |ov16[1:0];
      end
      FMT_PAIRED_WORD: begin
        simd_res = y32_flat;
        simd_ovf = |ov32;
      end
      FMT_W: begin
        simd_res = sext32(y32_flat[31:0]);
        simd_ovf = ov32[0];
      end
      FMT_L: begin
        simd_res = y64_flat;
        simd_ovf = ov64;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Doubleword load placement, byte k taken from address offset k, or offset 7-k when big-endian
  // ----------------------------------------------------------------------
  for (genvar k = 0; k < 8; k++) begin : g_load
    assign ld_word[8*k +: 8] = big_endian ? load_bytes[8*(7-k) +: 8]
                                          : load_bytes[8*k +: 8];
  end

  // ----------------------------------------------------------------------
  // Operation datapath and flag events
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [32:0] p0;
    logic [32:0] p1;
    logic [16:0] h_hi;
    logic [16:0] h_lo;
    logic [65:0] sum;
    logic [64:0] ex;
    logic [64:0] ex_rnd;
    logic ovf;
    src_a = '0;
    src_b = '0;
    p0 = '0;
    p1 = '0;
    h_hi = '0;
    h_lo = '0;
    sum = '0;
    ex = '0;
    ex_rnd = '0;
    ovf = 1'b0;
    res_next = '0;
    acc_next = acc_in;
    acc_we = 1'b0;
    ev = '0;
    unique case (op)
      OP_ADD, OP_SUB: begin
        res_next = simd_res;
        ev[FLAG_ADDSUB] = simd_ovf;
      end
      OP_SHL: begin
        res_next = simd_res;
        ev[FLAG_SHIFT] = simd_ovf;
      end
      OP_MULQ, OP_MUL: begin
        res_next = simd_res;
        ev[FLAG_MUL] = simd_ovf;
      end
      OP_MULEQ: begin
        // Input halves: the pair of a paired-half, or left/right of a quad
        if (in_fmt == FMT_QUAD_HALF && sel_left) begin
          src_a = rs_data[63:32];
          src_b = rt_data[63:32];
        end else begin
          src_a = rs_data[31:0];
          src_b = rt_data[31:0];
        end
        p1 = mulq_exp(src_a[31:16], src_b[31:16]);
        p0 = mulq_exp(src_a[15:0], src_b[15:0]);
        res_next = {p1[31:0], p0[31:0]};
        ev[FLAG_MUL] = p1[32] | p0[32];
      end
      OP_DOT: begin
        p1 = mulq_exp(rs_data[31:16], rt_data[31:16]);
        p0 = mulq_exp(rs_data[15:0], rt_data[15:0]);
        sum = {{2{acc_in[63]}}, acc_in} + {{34{p1[31]}}, p1[31:0]}
            + {{34{p0[31]}}, p0[31:0]};
        ovf = (sum[65:63] != 3'b000) && (sum[65:63] != 3'b111);
        acc_next = sum[63:0];
        if (ovf && acc_sat) begin
          acc_next = sum[65] ? {1'b1, 63'h0} : {1'b0, {63{1'b1}}};
        end
        acc_we = 1'b1;
        ev[FLAG_ACC0 + 32'(acc_sel)] = ovf | p1[32] | p0[32];
      end
      OP_PREC: begin
        h_hi = prec_half(rs_data[31:0], round);
        h_lo = prec_half(rt_data[31:0], round);
        res_next = sext32({h_hi[15:0], h_lo[15:0]});
        ev[FLAG_SHIFT] = h_hi[16] | h_lo[16];
      end
      OP_EXTR: begin
        // Round by half the lsb of the extracted field, then clamp
        ex_rnd = (round && shamt != 6'h00) ? (65'h1 << (shamt - 6'h01))
                                           : 65'h0;
        ex = $signed({acc_in[63], acc_in} + ex_rnd) >>> shamt;
        ovf = (ex[64:31] != {34{1'b0}}) && (ex[64:31] != {34{1'b1}});
        res_next = sext32(ex[31:0]);
        if (ovf && saturate) begin
          res_next = ex[64] ? sext32({1'b1, 31'h0}) : sext32(Q31_MAX);
        end
        ev[FLAG_EXTRACT] = ovf;
      end
      OP_LOAD: begin
        res_next = ld_word;
      end
      default: begin
        res_next = '0; // Spare operation codes give zero, set no flag
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Sticky flags: a write replaces them, a same-cycle event still lands
  // ----------------------------------------------------------------------
  always_comb begin
    ouflag_next = (flag_wr ? flag_wdata : ouflag_reg)
                | (op_valid ? ev : 8'h00);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ouflag_reg <= OUFLAG_RST;
    end else begin
      ouflag_reg <= ouflag_next;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers, one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_valid_reg <= 1'b0;
      result_reg <= DATA_RST;
    end else begin
      result_valid_reg <= op_valid && !acc_we;
      if (op_valid && !acc_we) begin
        result_reg <= res_next;
      end
    end
  end

  // Accumulator results leave on their own port for the caller to store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_valid_reg <= 1'b0;
      acc_reg <= DATA_RST;
    end else begin
      acc_valid_reg <= op_valid && acc_we;
      if (op_valid && acc_we) begin
        acc_reg <= acc_next;
      end
    end
  end

  assign result_valid = result_valid_reg;
  assign result_data = result_reg;
  assign acc_valid = acc_valid_reg;
  assign acc_data = acc_reg;
  assign ouflag = ouflag_reg;

endmodule : simd_sat_alu

/* File: dv/simd_sat_alu_assertions.sv */
// Concurrent checks on the ports of the SIMD datapath
`timescale 1ns/10ps
module simd_sat_alu_assertions
  import simd_alu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire simd_alu_pkg::op_t op,
  input wire simd_alu_pkg::fmt_t out_fmt,
  input wire logic is_signed,
  input wire logic saturate,
  input wire logic [63:0] rs_data,
  input wire logic [63:0] rt_data,
  input wire logic big_endian,
  input wire logic [63:0] load_bytes,
  input wire logic flag_wr,
  input wire logic [7:0] flag_wdata,
  input wire logic result_valid,
  input wire logic [63:0] result_data,
  input wire logic acc_valid,
  input wire logic [7:0] ouflag
);
  // ----------------------------------------------------------------------
  // Request shapes
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_req(op_t k);
    op_valid && op == k;
  endsequence
  sequence s_lane_req;
    op_valid && op != OP_DOT && op <= OP_LOAD;
  endsequence
  sequence s_word_add;
    s_req(OP_ADD) ##0 out_fmt inside {FMT_W, FMT_PAIRED_HALF, FMT_QUAD_BYTE};
  endsequence
  sequence s_minus_one;
    s_req(OP_MULQ) ##0 out_fmt == FMT_QUAD_HALF && is_signed && saturate
      && rs_data == 64'h8000_8000_8000_8000 && rt_data == rs_data;
  endsequence
  sequence s_u8_ovf;
    s_req(OP_ADD) ##0 out_fmt == FMT_OCTAL_BYTE && !is_signed && saturate
      && rs_data == 64'hFFFF_FFFF_FFFF_FFFF && rt_data[0];
  endsequence

  // ----------------------------------------------------------------------
  // Answers, placement, flags
  // ----------------------------------------------------------------------
  chk_lane_answer: assert property (
    s_lane_req |=> result_valid && !acc_valid)
    else $error("lane request without one-cycle answer");
  chk_dot_answer: assert property (
    s_req(OP_DOT) |=> acc_valid && !result_valid)
    else $error("dot request without accumulator answer");
  chk_idle_quiet: assert property (
    !op_valid |=> !result_valid && !acc_valid && $stable(result_data))
    else $error("answer or data change without request");
  chk_upper_sign: assert property (
    s_word_add |=> result_data[63:32] == {32{result_data[31]}})
    else $error("upper word is not the sign copy");
  chk_load_first: assert property (
    s_req(OP_LOAD) |=> ($past(big_endian) ?
      result_data[63:56] : result_data[7:0]) == $past(load_bytes[7:0]))
    else $error("lowest address byte misplaced");
  chk_load_last: assert property (
    s_req(OP_LOAD) |=> ($past(big_endian) ?
      result_data[7:0] : result_data[63:56]) == $past(load_bytes[63:56]))
    else $error("last element misplaced");
  chk_flag_sticky: assert property (
    !flag_wr |=> (ouflag & $past(ouflag)) == $past(ouflag))
    else $error("sticky flag cleared without a write");
  chk_flag_write: assert property (
    flag_wr && !op_valid |=> ouflag == $past(flag_wdata))
    else $error("flag write value not taken");
  chk_frac_minus: assert property (
    s_minus_one |=> result_data == 64'h7FFF_7FFF_7FFF_7FFF)
    else $error("minus one squared not clamped");
  chk_u8_clamp: assert property (
    s_u8_ovf |=> result_data == 64'hFFFF_FFFF_FFFF_FFFF && ouflag[FLAG_ADDSUB])
    else $error("unsigned byte overflow not clamped");
endmodule : simd_sat_alu_assertions

bind simd_sat_alu simd_sat_alu_assertions u_chk (
  .ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op(op),
  .out_fmt(out_fmt), .is_signed(is_signed), .saturate(saturate),
  .rs_data(rs_data), .rt_data(rt_data), .big_endian(big_endian),
  .load_bytes(load_bytes), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
  .result_valid(result_valid), .result_data(result_data),
  .acc_valid(acc_valid), .ouflag(ouflag));

/* File: dv/simd_wb_model.sv */
// Register file write-back side of the datapath
`timescale 1ns/10ps
module simd_wb_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic result_valid,
  input wire logic [63:0] result_data,
  output logic [63:0] wb_reg,
  output logic [7:0] wb_count
);
  // ----------------------------------------------------------------------
  // Destination write on each answer pulse
  // ----------------------------------------------------------------------
  // Counting pulses exposes a lost or doubled back-to-back answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_reg <= 64'h0000_0000_0000_0000;
      wb_count <= 8'h00;
    end else if (result_valid) begin
      wb_reg <= result_data;
      wb_count <= wb_count + 8'h01;
    end
  end
endmodule : simd_wb_model

/* File: dv/simd_saturating_fixed_point_alu_bench.sv */
// Self-checking bench of the SIMD saturating datapath
`timescale 1ns/10ps
module simd_saturating_fixed_point_alu_bench;
  import simd_alu_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, op_valid = 1'b0;
  op_t op = OP_ADD;
  fmt_t out_fmt = FMT_L, in_fmt = FMT_QUAD_HALF;
  logic is_signed = 1'b0, saturate = 1'b0, round = 1'b0;
  logic acc_sat = 1'b0, sel_left = 1'b0, big_endian = 1'b0;
  logic flag_wr = 1'b0;
  logic [5:0] shamt = 6'h01;
  logic [1:0] acc_sel = 2'h0;
  logic [7:0] flag_wdata = 8'h00, ouflag, wb_count;
  logic [63:0] rs_data = '0, rt_data = '0, acc_in = '0, load_bytes = '0;
  logic [63:0] result_data, acc_data, wb_reg;
  logic result_valid, acc_valid;
  int n_fail = 0, check_count = 0;

  simd_sat_alu dut (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid),
    .op(op), .out_fmt(out_fmt), .in_fmt(in_fmt), .is_signed(is_signed),
    .saturate(saturate), .round(round), .acc_sat(acc_sat),
    .sel_left(sel_left), .shamt(shamt), .acc_sel(acc_sel),
    .rs_data(rs_data), .rt_data(rt_data), .acc_in(acc_in),
    .big_endian(big_endian), .load_bytes(load_bytes), .flag_wr(flag_wr),
    .flag_wdata(flag_wdata), .result_valid(result_valid),
    .result_data(result_data), .acc_valid(acc_valid),
    .acc_data(acc_data), .ouflag(ouflag));
  simd_wb_model wb (.ref_clk(ref_clk), .rst(rst),
    .result_valid(result_valid), .result_data(result_data),
    .wb_reg(wb_reg), .wb_count(wb_count));

  // ----------------------------------------------------------------------
  // Clock, shared tasks
  // ----------------------------------------------------------------------
  initial forever #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One request; data looked at once its answer edge has landed
  task automatic run(input op_t o, input fmt_t f, input logic [2:0] m,
                     input logic [63:0] a, input logic [63:0] b);
    @(posedge ref_clk);
    op <= o;
    out_fmt <= f;
    {is_signed, saturate, round} <= m;
    rs_data <= a;
    rt_data <= b;
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    @(negedge ref_clk);
  endtask : run

  task automatic fwr(input logic [7:0] v);
    @(posedge ref_clk);
    flag_wr <= 1'b1;
    flag_wdata <= v;
    @(posedge ref_clk);
    flag_wr <= 1'b0;
    @(negedge ref_clk);
    chk(64'(ouflag), 64'(v));
  endtask : fwr

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_unsigned;
    run(OP_ADD, FMT_OCTAL_BYTE, 3'b010, '1, 64'h0101_0101_0101_0101);
    chk(result_data, 64'hFFFF_FFFF_FFFF_FFFF);
    run(OP_ADD, FMT_OCTAL_BYTE, 3'b010, 64'hFF10_8000_0102_0304,
        64'h0110_8001_0102_0304);
    chk(result_data, 64'hFF20_FF01_0204_0608);
    run(OP_SUB, FMT_OCTAL_BYTE, 3'b010, 64'h0010_2030_4050_6070,
        64'h0101_1040_0000_0080);
    chk(result_data, 64'h000F_1000_4050_6000);
    run(OP_SHL, FMT_OCTAL_BYTE, 3'b010, 64'h807F_0102_0304_0506, '0);
    chk(result_data, 64'hFFFE_0204_0608_0A0C);
    $display("test unsigned done");
  endtask : t_unsigned

  task automatic t_signed;
    fwr(8'h00);
    run(OP_ADD, FMT_QUAD_HALF, 3'b100, 64'h7FFF_8000_1234_FFFE,
        64'h0001_FFFF_0001_0003);
    chk(result_data, 64'h8000_7FFF_1235_0001);
    chk(64'(ouflag), 64'h0010);
    run(OP_ADD, FMT_QUAD_HALF, 3'b110, rs_data, rt_data);
    chk(result_data, 64'h7FFF_8000_1235_0001);
    run(OP_SUB, FMT_PAIRED_WORD, 3'b110, 64'h8000_0000_0000_0005,
        64'h0000_0001_0000_0007);
    chk(result_data, 64'h8000_0000_FFFF_FFFE);
    run(OP_SHL, FMT_QUAD_HALF, 3'b110, 64'h4000_C000_0001_B000, '0);
    chk(result_data, 64'h7FFF_8000_0002_8000);
    chk(64'(ouflag), 64'h0050);
    run(OP_ADD, FMT_W, 3'b110, 64'h0000_0000_8000_0000,
        64'h0000_0000_FFFF_FFFF);
    chk(result_data, 64'hFFFF_FFFF_8000_0000);
    run(OP_ADD, FMT_L, 3'b110, 64'h7FFF_FFFF_FFFF_FFFF, 64'h0001);
    chk(result_data, 64'h7FFF_FFFF_FFFF_FFFF);
    run(OP_ADD, FMT_PAIRED_HALF, 3'b110, 64'h1234_5678_7FFF_0001,
        64'h0000_0000_0001_0001);
    chk(result_data, 64'h0000_0000_7FFF_0002);
    $display("test signed done");
  endtask : t_signed

  task automatic t_frac;
    run(OP_MULQ, FMT_QUAD_HALF, 3'b111, 64'h8000_8000_8000_8000,
        64'h8000_8000_8000_8000);
    chk(result_data, 64'h7FFF_7FFF_7FFF_7FFF);
    run(OP_MULQ, FMT_QUAD_HALF, 3'b111, 64'h8000_4000_0001_8000,
        64'h8000_4000_4000_7FFF);
    chk(result_data, 64'h7FFF_2000_0001_8001);
    run(OP_MULQ, FMT_PAIRED_HALF, 3'b110, 64'h0001_8000,
        64'h4000_8000);
    chk(result_data, 64'h0000_0000_0000_7FFF);
    @(posedge ref_clk);
    sel_left <= 1'b1;
    run(OP_MULEQ, FMT_PAIRED_WORD, 3'b110, 64'h8000_4000_0002_C000,
        64'h8000_4000_0003_4000);
    chk(result_data, 64'h7FFF_FFFF_2000_0000);
    @(posedge ref_clk);
    sel_left <= 1'b0;
    big_endian <= 1'b1;
    run(OP_MULEQ, FMT_PAIRED_WORD, 3'b110, rs_data, rt_data);
    chk(result_data, 64'h0000_000C_E000_0000);
    run(OP_MUL, FMT_QUAD_BYTE, 3'b110, 64'h0000_0000_80F0_0302,
        64'h0000_0000_1002_0305);
    chk(result_data, 64'hFFFF_FFFF_80E0_090A);
    $display("test fractional done");
  endtask : t_frac

  task automatic t_accum;
    @(posedge ref_clk);
    acc_in <= 64'h7FFF_FFFF_FFFF_FFFF;
    acc_sat <= 1'b1;
    acc_sel <= 2'h2;
    run(OP_DOT, FMT_PAIRED_HALF, 3'b110, 64'h8000_8000, 64'h8000_8000);
    chk(64'(acc_valid), 64'h0001);
    chk(acc_data, 64'h7FFF_FFFF_FFFF_FFFF);
    chk(64'(ouflag[FLAG_ACC0+2]), 64'h0001);
    @(posedge ref_clk);
    acc_in <= '0;
    acc_sat <= 1'b0;
    run(OP_DOT, FMT_PAIRED_HALF, 3'b110, 64'h4000_4000, 64'h4000_4000);
    chk(acc_data, 64'h0000_0000_4000_0000);
    run(OP_PREC, FMT_PAIRED_HALF, 3'b111, 64'h1234_8000, 64'h7FFF_9000);
    chk(result_data, 64'h0000_0000_1235_7FFF);
    run(OP_PREC, FMT_PAIRED_HALF, 3'b111, 64'h8000_0000, 64'h0001_0000);
    chk(result_data, 64'hFFFF_FFFF_8000_0001);
    @(posedge ref_clk);
    shamt <= 6'h10;
    acc_in <= 64'h0000_0000_0001_8000;
    run(OP_EXTR, FMT_W, 3'b111, '0, '0);
    chk(result_data, 64'h0000_0000_0000_0002);
    @(posedge ref_clk);
    shamt <= 6'h01;
    acc_in <= 64'h0000_0001_0000_0000;
    run(OP_EXTR, FMT_W, 3'b110, '0, '0);
    chk(result_data, 64'h0000_0000_7FFF_FFFF);
    $display("test accumulate done");
  endtask : t_accum

  task automatic t_load_flags;
    @(posedge ref_clk);
    load_bytes <= 64'h0807_0605_0403_0201;
    run(OP_LOAD, FMT_L, 3'b000, '0, '0);
    chk(result_data, 64'h0102_0304_0506_0708);
    @(posedge ref_clk);
    big_endian <= 1'b0;
    run(OP_LOAD, FMT_L, 3'b000, '0, '0);
    chk(result_data, 64'h0807_0605_0403_0201);
    fwr(8'hA5);
    run(OP_ADD, FMT_OCTAL_BYTE, 3'b010, 64'h0001, 64'h0001);
    chk(64'(ouflag), 64'h00A5);
    // Two requests on consecutive edges, both must write back
    @(posedge ref_clk);
    op_valid <= 1'b1;
    @(posedge ref_clk);
    rs_data <= 64'h0002;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    // Second answer reaches the write-back one edge later
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(64'(wb_count), 64'h001A);
    chk(wb_reg, 64'h0000_0000_0000_0003);
    fwr(8'h00);
    $display("test load and flags done");
  endtask : t_load_flags

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_unsigned();
    t_signed();
    t_frac();
    t_accum();
    t_load_flags();
    test_done();
  end

  // Whole run is under a hundred cycles; this span is generous
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
endmodule : simd_saturating_fixed_point_alu_bench
